// ### hdl/eba_alu_top.v
// Eight-bit ALU datapath with an APB register interface.
`timescale 1ns/10ps
`include "eba_defines.vh"

module eba_alu_top (
   // Clock and reset
   input wire i_clk,
   input wire i_srst,
   // APB slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire [31:0] o_prdata,
   output wire o_pready,
   output wire o_pslverr,
   // Status
   output wire o_busy
);

   // ==========================================================
   // States
   localparam ST_IDLE = 2'b00;
   localparam ST_EXEC = 2'b01;
   localparam ST_SECOND = 2'b10;

   // ==========================================================
   // Decoding helpers
   function [1:0] op_class;
      input [4:0] op;
      begin
         case (op)
            `EBA_OP_WADD, `EBA_OP_WSUB: op_class = `EBA_CL_WORD;
            `EBA_OP_ADD, `EBA_OP_ADC, `EBA_OP_SUB, `EBA_OP_SUBK,
            `EBA_OP_SUBC, `EBA_OP_SUBCK: op_class = `EBA_CL_ARITH;
            `EBA_OP_MUL, `EBA_OP_SMUL, `EBA_OP_XMUL,
            `EBA_OP_FRMUL, `EBA_OP_FRSMUL, `EBA_OP_FRXMUL: op_class = `EBA_CL_MUL;
            default: op_class = `EBA_CL_LOGIC;
         endcase
      end
   endfunction

   function is_known;
      input [4:0] op;
      begin
         is_known = (op <= `EBA_OP_FRXMUL);
      end
   endfunction

   function is_mapped;
      input [7:0] addr;
      begin
         case (addr)
            `EBA_ADDR_CTRL, `EBA_ADDR_DST, `EBA_ADDR_SRC, `EBA_ADDR_IMM,
            `EBA_ADDR_HIGH, `EBA_ADDR_PROD, `EBA_ADDR_FLAGS,
            `EBA_ADDR_STATUS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // ==========================================================
   // Registers
   reg [1:0] state_ff;
   reg [4:0] op_ff;
   reg [7:0] dst_ff;
   reg [7:0] src_ff;
   reg [7:0] imm_ff;
   reg [7:0] high_ff;
   reg [15:0] prod_ff;
   reg [5:0] flags_ff;
   reg done_ff;
   reg [7:0] lo_tmp_ff;
   reg cy_tmp_ff;
   reg [31:0] rdata_ff;

   // ==========================================================
   // Bus decode
   wire setup_rd;
   wire wr_acc;
   wire go;
   wire idle;

   assign idle = (state_ff == ST_IDLE);
   assign setup_rd = i_psel & ~i_penable & ~i_pwrite;
   assign wr_acc = i_psel & i_penable & i_pwrite;
   assign go = wr_acc & (i_paddr == `EBA_ADDR_CTRL) & i_pwdata[`EBA_CTRL_GO] & idle
      & is_known(i_pwdata[4:0]);
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~is_mapped(i_paddr);
   assign o_prdata = rdata_ff;
   assign o_busy = ~idle;

   // ==========================================================
   // Operand selection for the adder
   wire [1:0] cls;
   wire in_second;
   wire uses_imm;
   wire is_sub;
   wire uses_cin;
   reg [7:0] as_a;
   reg [7:0] as_b;
   reg as_cin;
   wire [7:0] as_r;
   wire as_c;
   wire as_h;
   wire as_v;

   assign cls = op_class(op_ff);
   assign in_second = (state_ff == ST_SECOND);
   assign uses_imm = (op_ff == `EBA_OP_SUBK) | (op_ff == `EBA_OP_SUBCK) |
      (cls == `EBA_CL_WORD);
   assign is_sub = (op_ff == `EBA_OP_SUB) | (op_ff == `EBA_OP_SUBK) |
      (op_ff == `EBA_OP_SUBC) | (op_ff == `EBA_OP_SUBCK) | (op_ff == `EBA_OP_WSUB);
   assign uses_cin = (op_ff == `EBA_OP_ADC) | (op_ff == `EBA_OP_SUBC) |
      (op_ff == `EBA_OP_SUBCK);

   always @* begin
      if (in_second) begin
         // The upper byte of a pair only absorbs the carry or borrow.
         as_a = high_ff;
         as_b = 8'h00;
         as_cin = cy_tmp_ff;
      end else begin
         as_a = dst_ff;
         as_b = uses_imm ? imm_ff : src_ff;
         as_cin = uses_cin ? flags_ff[`EBA_FLAG_C] : 1'b0;
      end
   end

   eba_addsub8 u_addsub (
      .i_a(as_a),
      .i_b(as_b),
      .i_cin(as_cin),
      .i_sub(is_sub),
      .o_r(as_r),
      .o_c(as_c),
      .o_h(as_h),
      .o_v(as_v)
   );

   // ==========================================================
   // Multiplier
   wire mul_a_signed;
   wire mul_b_signed;
   wire [15:0] mul_p;
   wire mul_frac;

   assign mul_a_signed = (op_ff == `EBA_OP_SMUL) | (op_ff == `EBA_OP_XMUL) |
      (op_ff == `EBA_OP_FRSMUL) | (op_ff == `EBA_OP_FRXMUL);
   assign mul_b_signed = (op_ff == `EBA_OP_SMUL) | (op_ff == `EBA_OP_FRSMUL);
   assign mul_frac = (op_ff == `EBA_OP_FRMUL) | (op_ff == `EBA_OP_FRSMUL) |
      (op_ff == `EBA_OP_FRXMUL);

   eba_mult u_mult (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_load(state_ff == ST_EXEC),
      .i_a(dst_ff),
      .i_b(src_ff),
      .i_a_signed(mul_a_signed),
      .i_b_signed(mul_b_signed),
      .o_prod_ff(mul_p)
   );

   // ==========================================================
   // Logic unit
   reg [7:0] logic_r;

   always @* begin
      case (op_ff)
         `EBA_OP_AND: logic_r = dst_ff & src_ff;
         `EBA_OP_ANDK: logic_r = dst_ff & imm_ff;
         `EBA_OP_OR: logic_r = dst_ff | src_ff;
         `EBA_OP_ORK: logic_r = dst_ff | imm_ff;
         `EBA_OP_XOR: logic_r = dst_ff ^ src_ff;
         `EBA_OP_MSET: logic_r = dst_ff | imm_ff;
         `EBA_OP_MCLR: logic_r = dst_ff & (`EBA_ALL_ONES - imm_ff);
         `EBA_OP_TEST: logic_r = dst_ff & dst_ff;
         default: logic_r = dst_ff;
      endcase
   end

   // ==========================================================
   // Result and flag computation
   reg [15:0] nxt_prod;
   reg [15:0] nxt_word;
   reg [5:0] nxt_flags;

   always @* begin
      // every flag starts from its stored value
      nxt_flags = flags_ff;
      nxt_word = {as_r, lo_tmp_ff};
      nxt_prod = mul_frac ? {mul_p[14:0], 1'b0} : mul_p;
      case (cls)
         `EBA_CL_ARITH: begin
            // Z C N V H from the adder
            nxt_flags[`EBA_FLAG_Z] = (as_r == 8'h00);
            nxt_flags[`EBA_FLAG_C] = as_c;
            nxt_flags[`EBA_FLAG_N] = as_r[7];
            nxt_flags[`EBA_FLAG_V] = as_v;
            nxt_flags[`EBA_FLAG_H] = as_h;
         end
         `EBA_CL_WORD: begin
            nxt_flags[`EBA_FLAG_Z] = (nxt_word == 16'h0000);
            nxt_flags[`EBA_FLAG_C] = as_c;
            nxt_flags[`EBA_FLAG_N] = as_r[7];
            nxt_flags[`EBA_FLAG_V] = as_v;
            nxt_flags[`EBA_FLAG_S] = as_r[7] ^ as_v;
         end
         `EBA_CL_LOGIC: begin
            nxt_flags[`EBA_FLAG_Z] = (logic_r == 8'h00);
            nxt_flags[`EBA_FLAG_N] = logic_r[7];
            nxt_flags[`EBA_FLAG_V] = 1'b0;
         end
         `EBA_CL_MUL: begin
            nxt_flags[`EBA_FLAG_Z] = (nxt_prod == 16'h0000);
            nxt_flags[`EBA_FLAG_C] = mul_p[15];
         end
         default: begin
            nxt_flags = flags_ff;
         end
      endcase
   end

   // ==========================================================
   // Sequencer and register file
   always @(posedge i_clk) begin
      if (i_srst) begin
         state_ff <= ST_IDLE;
         op_ff <= `EBA_RST_OP;
         dst_ff <= `EBA_RST_BYTE;
         src_ff <= `EBA_RST_BYTE;
         imm_ff <= `EBA_RST_BYTE;
         high_ff <= `EBA_RST_BYTE;
         prod_ff <= 16'h0000;
         flags_ff <= `EBA_RST_FLAGS;
         done_ff <= 1'b0;
         lo_tmp_ff <= `EBA_RST_BYTE;
         cy_tmp_ff <= 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               // Operand writes are only taken while idle, so the datapath
               // never sees a register change in the middle of an operation.
               if (wr_acc) begin
                  case (i_paddr)
                     `EBA_ADDR_DST: dst_ff <= i_pwdata[7:0];
                     `EBA_ADDR_SRC: src_ff <= i_pwdata[7:0];
                     `EBA_ADDR_IMM: imm_ff <= i_pwdata[7:0];
                     `EBA_ADDR_HIGH: high_ff <= i_pwdata[7:0];
                     `EBA_ADDR_FLAGS: flags_ff <= i_pwdata[5:0];
                     default: begin
                     end
                  endcase
               end
               if (go) begin
                  op_ff <= i_pwdata[4:0];
                  done_ff <= 1'b0;
                  state_ff <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               case (cls)
                  `EBA_CL_WORD: begin
                     lo_tmp_ff <= as_r;
                     cy_tmp_ff <= as_c;
                     state_ff <= ST_SECOND;
                  end
                  `EBA_CL_MUL: begin
                     state_ff <= ST_SECOND;
                  end
                  `EBA_CL_ARITH: begin
                     dst_ff <= as_r;
                     flags_ff <= nxt_flags;
                     done_ff <= 1'b1;
                     state_ff <= ST_IDLE;
                  end
                  default: begin
                     dst_ff <= logic_r;
                     flags_ff <= nxt_flags;
                     done_ff <= 1'b1;
                     state_ff <= ST_IDLE;
                  end
               endcase
            end
            ST_SECOND: begin
               if (cls == `EBA_CL_WORD) begin
                  dst_ff <= nxt_word[7:0];
                  high_ff <= nxt_word[15:8];
               end else begin
                  prod_ff <= nxt_prod;
               end
               flags_ff <= nxt_flags;
               done_ff <= 1'b1;
               state_ff <= ST_IDLE;
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Read data is captured in the setup phase so the access phase needs no wait.
   always @(posedge i_clk) begin
      if (i_srst) begin
         rdata_ff <= 32'h00000000;
      end else if (setup_rd) begin
         case (i_paddr)
            `EBA_ADDR_CTRL: rdata_ff <= {27'h0, op_ff};
            `EBA_ADDR_DST: rdata_ff <= {24'h000000, dst_ff};
            `EBA_ADDR_SRC: rdata_ff <= {24'h000000, src_ff};
            `EBA_ADDR_IMM: rdata_ff <= {24'h000000, imm_ff};
            `EBA_ADDR_HIGH: rdata_ff <= {24'h000000, high_ff};
            `EBA_ADDR_PROD: rdata_ff <= {16'h0000, prod_ff};
            `EBA_ADDR_FLAGS: rdata_ff <= {26'h0, flags_ff};
            `EBA_ADDR_STATUS: rdata_ff <= {30'h0, done_ff, ~idle};
            default: rdata_ff <= 32'h00000000;
         endcase
      end
   end

endmodule

// ### hdl/eba_defines.vh
// Register offsets, field positions, opcodes and reset values of the ALU datapath.
`ifndef EBA_DEFINES_VH
`define EBA_DEFINES_VH

// ==========================================================
// Register byte offsets
`define EBA_ADDR_CTRL   8'h00
`define EBA_ADDR_DST    8'h04
`define EBA_ADDR_SRC    8'h08
`define EBA_ADDR_IMM    8'h0C
`define EBA_ADDR_HIGH   8'h10
`define EBA_ADDR_PROD   8'h14
`define EBA_ADDR_FLAGS  8'h18
`define EBA_ADDR_STATUS 8'h1C

// ==========================================================
// Field positions
`define EBA_CTRL_GO     8
`define EBA_FLAG_C      0
`define EBA_FLAG_Z      1
`define EBA_FLAG_N      2
`define EBA_FLAG_V      3
`define EBA_FLAG_S      4
`define EBA_FLAG_H      5
`define EBA_STAT_BUSY   0
`define EBA_STAT_DONE   1

// ==========================================================
// Reset values
`define EBA_RST_BYTE    8'h00
`define EBA_RST_FLAGS   6'h00
`define EBA_RST_OP      5'h00

// ==========================================================
// Operation codes
`define EBA_OP_ADD      5'h00
`define EBA_OP_ADC      5'h01
`define EBA_OP_WADD     5'h02
`define EBA_OP_SUB      5'h03
`define EBA_OP_SUBK     5'h04
`define EBA_OP_SUBC     5'h05
`define EBA_OP_SUBCK    5'h06
`define EBA_OP_WSUB     5'h07
`define EBA_OP_AND      5'h08
`define EBA_OP_ANDK     5'h09
`define EBA_OP_OR       5'h0A
`define EBA_OP_ORK      5'h0B
`define EBA_OP_XOR      5'h0C
`define EBA_OP_MSET     5'h0D
`define EBA_OP_MCLR     5'h0E
`define EBA_OP_TEST     5'h0F
`define EBA_OP_MUL      5'h10
`define EBA_OP_SMUL     5'h11
`define EBA_OP_XMUL     5'h12
`define EBA_OP_FRMUL    5'h13
`define EBA_OP_FRSMUL   5'h14
`define EBA_OP_FRXMUL   5'h15

// ==========================================================
// Operation classes
`define EBA_CL_ARITH    2'h0
`define EBA_CL_WORD     2'h1
`define EBA_CL_LOGIC    2'h2
`define EBA_CL_MUL      2'h3

// ==========================================================
// Bit-clear complement base
`define EBA_ALL_ONES    8'hFF

`endif

// ### hdl/eba_addsub8.v
// Eight-bit adder and subtractor with carry, half-carry and overflow outputs.
`timescale 1ns/10ps
module eba_addsub8 (
   // Operands
   input wire [7:0] i_a,
   input wire [7:0] i_b,
   input wire i_cin,
   input wire i_sub,
   // Result and flags
   output wire [7:0] o_r,
   output wire o_c,
   output wire o_h,
   output wire o_v
);

   // ==========================================================
   // Subtraction is a plus inverted b plus inverted borrow.
   wire [7:0] bb;
   wire cx;
   wire [8:0] sum;
   wire [4:0] nib;

   assign bb = i_sub ? ~i_b : i_b;
   assign cx = i_sub ? ~i_cin : i_cin;
   assign sum = {1'b0, i_a} + {1'b0, bb} + {8'h00, cx};
   assign nib = {1'b0, i_a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cx};
   assign o_r = sum[7:0];
   assign o_c = i_sub ? ~sum[8] : sum[8];
   assign o_h = i_sub ? ~nib[4] : nib[4];
   assign o_v = (i_a[7] == bb[7]) && (sum[7] != i_a[7]);

endmodule

// ### hdl/eba_mult.v
// Registered eight-by-eight multiplier with per-operand signedness.
`timescale 1ns/10ps
module eba_mult (
   // Clock and reset
   input wire i_clk,
   input wire i_srst,
   // Operands
   input wire i_load,
   input wire [7:0] i_a,
   input wire [7:0] i_b,
   input wire i_a_signed,
   input wire i_b_signed,
   // Product
   output reg [15:0] o_prod_ff
);

   // ==========================================================
   // Nine-bit extension lets one signed multiplier serve all three sign mixes.
   wire signed [8:0] ax;
   wire signed [8:0] bx;
   wire signed [17:0] prod;

   assign ax = {i_a_signed & i_a[7], i_a};
   assign bx = {i_b_signed & i_b[7], i_b};
   assign prod = ax * bx;

   always @(posedge i_clk) begin
      if (i_srst) begin
         o_prod_ff <= 16'h0000;
      end else if (i_load) begin
         o_prod_ff <= prod[15:0];
      end
   end

endmodule

// ### dv/eba_apb_host.sv
// Bus-master model of the decoder side that loads and reads the ALU registers.
`timescale 1ns/10ps
module eba_apb_host (
   // Clock and answer
   input wire i_clk,
   input wire i_pready,
   input wire i_pslverr,
   input wire [31:0] i_prdata,
   // Request
   output reg o_psel,
   output reg o_penable,
   output reg o_pwrite,
   output reg [7:0] o_paddr,
   output reg [31:0] o_pwdata
);
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 8'h00;
      o_pwdata = 32'h0;
   end
   // ====
   // Transfer: held until pready is sampled high; data is inverted once released.
   task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
      begin
         @(posedge i_clk);
         o_psel <= 1'b1;
         o_penable <= 1'b0;
         o_pwrite <= w;
         o_paddr <= a;
         o_pwdata <= d;
         @(posedge i_clk);
         o_penable <= 1'b1;
         @(posedge i_clk);
         while (i_pready !== 1'b1)
            @(posedge i_clk);
         q = i_prdata;
         e = i_pslverr;
         o_psel <= 1'b0;
         o_penable <= 1'b0;
         o_pwdata <= ~d;
      end
   endtask
endmodule

// ### dv/eba_alu_checker.sv
// Concurrent checks on the bus and busy ports of the ALU datapath.
`timescale 1ns/10ps
`include "eba_defines.vh"
module eba_alu_checker (
   // Clock and reset
   input wire i_clk,
   input wire i_srst,
   // Watched ports
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [31:0] o_prdata,
   input wire o_pready,
   input wire o_pslverr,
   input wire o_busy
);
   // ====
   // Decoded requests
   wire [4:0] op = i_pwdata[4:0];
   wire acc = i_psel && i_penable;
   wire bad = i_paddr[1:0] != 2'h0 || i_paddr > `EBA_ADDR_STATUS;
   wire go = acc && i_pwrite && i_paddr == `EBA_ADDR_CTRL && i_pwdata[`EBA_CTRL_GO] && !o_busy;
   wire ok = go && op <= `EBA_OP_FRXMUL;
   wire wd = op == `EBA_OP_WADD || op == `EBA_OP_WSUB;
   wire ml = op >= `EBA_OP_MUL;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // ====
   // Properties
   a_ready_always: assert property (o_pready) else $error("pready low");
   a_err_unmapped: assert property (o_pslverr == (acc && bad)) else $error("pslverr wrong");
   a_busy_single: assert property (ok && !wd && !ml |=> o_busy ##1 !o_busy)
      else $error("short op busy wrong");
   a_busy_word: assert property (ok && wd |=> o_busy [*2] ##1 !o_busy)
      else $error("word op busy wrong");
   a_busy_mul: assert property (ok && ml |=> o_busy [*2] ##1 !o_busy)
      else $error("multiply busy wrong");
   a_idle_hold: assert property (!o_busy && !ok |=> !o_busy) else $error("busy without go");
   a_reset_clear: assert property (disable iff (1'b0) i_srst |=> !o_busy && o_prdata == 32'h0)
      else $error("reset state wrong");
   a_rdata_hold: assert property (!(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata))
      else $error("read data moved");
   c_single: cover property (ok && !wd && !ml);
   c_mul: cover property (ok && ml);
   c_word: cover property (ok && wd);
   c_err: cover property (acc && bad);
endmodule

// ### dv/tb_eight_bit_alu_datapath.sv
// Self-checking bench of the ALU datapath against a behavioural model.
`timescale 1ns/10ps
`include "eba_defines.vh"
module tb_eight_bit_alu_datapath;
   reg i_clk;
   reg i_srst;
   wire psel, pen, pwr, rdy, err, busy;
   wire [7:0] addr;
   wire [31:0] wdat, rdat;
   integer num_errors = 0;
   integer check_count = 0;
   integer seed = 32'h8b18c61f;
   integer i, j;
   reg [31:0] q;
   reg [31:0] v [1:6];
   reg e, done;
   reg [7:0] d, s, k, h;
   reg [15:0] p;
   reg [5:0] f;
   reg [4:0] op, lop;
   eba_alu_top dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(rdat), .o_pready(rdy),
      .o_pslverr(err), .o_busy(busy));
   eba_apb_host host_u (.i_clk(i_clk), .i_pready(rdy), .i_pslverr(err), .i_prdata(rdat),
      .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(addr), .o_pwdata(wdat));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // ====
   // Bus and compare tasks
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] x);
      host_u.xfer(1'b1, a, x, q, e);
   endtask
   task rdc(input [7:0] a, input [31:0] x, input xe);
      begin
         host_u.xfer(1'b0, a, 32'h0, q, e);
         chk(q, x);
         chk({31'h0, e}, {31'h0, xe});
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", check_count, num_errors);
         if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // ====
   // Reference model
   task model;
      integer a, b, r, t, c;
      begin
         // Bit n of the mask marks an opcode that takes SRC rather than IMM.
         b = ((32'h003F152B >> op) & 1) ? s : k;
         c = (op == 1 || op == 5 || op == 6) ? f[0] : 0;
         a = (op < 3) ? 1 : -1;
         if (op <= 6 && op != 2) begin
            r = d + a * (b + c);
            t = d % 16 + a * (b % 16 + c);
            f = {t > 15 || t < 0, f[4], (d[7] ^ b[7]) == (a < 0) && r[7] != d[7], r[7],
               r[7:0] == 0, r > 255 || r < 0};
            d = r[7:0];
         end
         else if (op == 2 || op == 7) begin
            r = {h, d} + a * k;
            t = a > 0 ? !h[7] && r[15] : h[7] && !r[15];
            f = {f[5], r[15] ^ t[0], t[0], r[15], r[15:0] == 0, r > 65535 || r < 0};
            {h, d} = r[15:0];
         end
         else if (op <= 15) begin
            r = op == 15 ? d : op < 10 ? d & b : op == 12 ? d ^ b :
               op == 14 ? d & (8'hFF - k) : d | b;
            f = {f[5:4], 1'b0, r[7], r[7:0] == 0, f[0]};
            d = r[7:0];
         end
         else if (op <= 21) begin
            a = (op == 17 || op == 18 || op == 20 || op == 21) ? d - 256 * d[7] : d;
            b = (op == 17 || op == 20) ? s - 256 * s[7] : s;
            r = a * b;
            p = op > 18 ? r[15:0] << 1 : r[15:0];
            f = {f[5:2], p == 16'h0, r[15]};
         end
         if (op <= 21) begin
            lop = op;
            done = 1'b1;
         end
      end
   endtask
   // ====
   // Main sequence
   initial begin
      i_srst = 1'b1;
      {d, s, k, h, p, f, lop, done} = 0;
      repeat (6) @(posedge i_clk);
      i_srst <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
         rdc(8'(i * 4), 32'h0, 1'b0);
      rdc(8'h20, 32'h0, 1'b1);
      rdc(8'hFC, 32'h0, 1'b1);
      $display("reset and decode test done");
      for (i = 0; i < 300; i = i + 1) begin
         op = i < 32 ? i[4:0] : $random(seed);
         for (j = 1; j < 7; j = j + 1) begin
            v[j] = $random(seed);
            wr(8'(j * 4), v[j]);
         end
         d = v[1][7:0];
         s = v[2][7:0];
         k = v[3][7:0];
         h = v[4][7:0];
         f = v[6][5:0];
         wr(`EBA_ADDR_CTRL, {23'h0, 1'b1, 3'h0, op});
         model;
         q = 32'h1;
         for (j = 0; j < 20 && q[0] !== 1'b0; j = j + 1)
            host_u.xfer(1'b0, `EBA_ADDR_STATUS, 32'h0, q, e);
         rdc(`EBA_ADDR_DST, {24'h0, d}, 1'b0);
         rdc(`EBA_ADDR_HIGH, {24'h0, h}, 1'b0);
         rdc(`EBA_ADDR_PROD, {16'h0, p}, 1'b0);
         rdc(`EBA_ADDR_FLAGS, {26'h0, f}, 1'b0);
         rdc(`EBA_ADDR_STATUS, {30'h0, done, 1'b0}, 1'b0);
         rdc(`EBA_ADDR_CTRL, {27'h0, lop}, 1'b0);
      end
      $display("random operation test done");
      complete_run;
   end
   initial begin
      repeat (40000) @(posedge i_clk);
      num_errors = num_errors + 1;
      complete_run;
   end
endmodule
bind eba_alu_top eba_alu_checker chk_u (.i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_busy(o_busy));
